// >>> hdl/host_bus_slave_dma.sv
// Host bus slave, interrupt poster and word fetch engine of the multiplexer controller.
`timescale 1ns/1ps
module host_bus_slave_dma #(
	parameter int NUM_EMUL = 2,
	parameter int DECODE_VARIANT = 0
)(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Host bus pins, each open line split into in, out and enable.
	input wire logic [hbus_pkg::ADDR_W-1:0] addrIn,
	output logic [hbus_pkg::ADDR_W-1:0] addrOut,
	output logic addrOe,
	input wire logic [hbus_pkg::DATA_W-1:0] dataIn,
	output logic [hbus_pkg::DATA_W-1:0] dataOut,
	output logic dataOe,
	input wire hbus_pkg::busIn_t ctlIn,
	output hbus_pkg::busCtl_t ctlOut,
	output hbus_pkg::busCtl_t ctlOe,
	output logic npgOut,
	output logic bg5Out,
	// Option switches.
	input wire logic [3:0] baseAddressSwitch,
	input wire logic dsrSwitch,
	input wire logic [2*hbus_pkg::MAX_GROUPS-1:0] wrapSwitch,
	// Clear and self-test towards the firmware.
	output logic ctrlClear,
	output logic selfTestStart,
	output logic linesDisabled,
	input wire logic paramsLoaded,
	// Register access handed to the firmware.
	output logic slvReq,
	output logic [7:0] slvOffset,
	output logic slvWrite,
	output logic slvByte,
	output logic [hbus_pkg::DATA_W-1:0] slvWdata,
	input wire logic slvAck,
	input wire logic [hbus_pkg::DATA_W-1:0] slvRdata,
	// Interrupt requests with programmed vectors.
	input wire logic irqReq,
	input wire logic [hbus_pkg::DATA_W-1:0] irqVector,
	output logic irqDone,
	// Word fetch requests and fetched words.
	input wire logic dmaReq,
	input wire logic [hbus_pkg::ADDR_W-1:0] dmaAddr,
	output logic dmaDone,
	output logic nonexistentMemoryError,
	output logic wordValid,
	input wire logic wordReady,
	output hbus_pkg::dmaWord_t wordOut,
	// Line adapter indicators and options.
	input wire logic [7:0] lineFault,
	output logic [7:0] faultLed,
	output logic dsrRewired,
	output logic [2*hbus_pkg::MAX_GROUPS-1:0] wrapMode
);
	// Refuse configurations the decode and window logic cannot serve.
	if (NUM_EMUL < 1 || NUM_EMUL > hbus_pkg::MAX_GROUPS ||
		DECODE_VARIANT < 0 || DECODE_VARIANT >= hbus_pkg::VARIANTS)
	begin : g_bad_cfg
		$error("host_bus_slave_dma: unsupported configuration");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: three stages, a change counts once stages two and three agree.

	hbus_pkg::pins_t rawPins, s1, s2, s3, pin, next_pin;

	assign rawPins = '{addr: addrIn, data: dataIn, ctl: ctlIn, dsrSwitch: dsrSwitch,
		baseAddressSwitch: baseAddressSwitch, wrapSwitch: wrapSwitch};

	// Bitwise agreement filter; stage one is only read by stage two.
	always_comb
	begin
		next_pin = (s3 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
	end

	// Registers only.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin <= '0;
		end
		else
		begin
			s1 <= rawPins;
			s2 <= s1;
			s3 <= s2;
			pin <= next_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decode from a pair of lookup memories.

	// Slot address for entry i of the decode memories.
	function automatic logic [17:0] slotAddr(input int i);
		slotAddr = hbus_pkg::FIRST_BASE + 18'(i) * hbus_pkg::SLOT_STEP;
	endfunction

	logic [8:0] decodeHi [hbus_pkg::SLOTS]; // Upper half of each base.
	logic [8:0] decodeLo [hbus_pkg::SLOTS]; // Lower half of each base.
	for (genvar i = 0; i < hbus_pkg::SLOTS; i++)
	begin : g_decode
		localparam logic [17:0] SLOT = slotAddr(i); // Base held in entry i.
		assign decodeHi[i] = SLOT[17:9];
		assign decodeLo[i] = SLOT[8:0];
	end

	logic swOk, hit;
	logic [5:0] selIdx;
	logic [17:0] base, offsetFull;
	localparam logic [17:0] WINDOW = 18'(NUM_EMUL * hbus_pkg::EMUL_BYTES);

	// Switch values past the last base leave the device off the bus.
	always_comb
	begin
		swOk = pin.baseAddressSwitch < 4'(hbus_pkg::BASES_PER);
		selIdx = swOk ? 6'(DECODE_VARIANT * hbus_pkg::BASES_PER) +
			{2'h0, pin.baseAddressSwitch} : 6'h00;
		base = {decodeHi[selIdx], decodeLo[selIdx]};
		offsetFull = pin.addr - base;
		hit = swOk && pin.addr >= base && offsetFull < WINDOW;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus sequencer, clear handling and option outputs.

	// Bus sequencer states; kept local so the bare state names resolve here.
	typedef enum logic [3:0] {
		S_IDLE, S_SLV_WAIT, S_SLV_END, S_ARB, S_SACK,
		S_DESKEW, S_DMA_WAIT, S_INTR, S_RELEASE
	} busState_t;
	busState_t state, next_state;
	logic [hbus_pkg::CNT_W-1:0] cnt, next_cnt; // Deskew and timeout count.
	logic kindDma, next_kindDma; // Arbitration is for a fetch, not a vector.
	logic powerLowSeen, next_powerLowSeen;
	logic busClear, grantIn, push;
	hbus_pkg::busCtl_t next_ctlOut;
	hbus_pkg::dmaWord_t pushWord;
	logic [17:0] next_addrOut;
	logic [15:0] next_dataOut, next_slvWdata;
	logic [7:0] next_slvOffset;
	logic next_addrOe, next_dataOe, next_slvReq, next_slvWrite, next_slvByte;
	logic next_irqDone, next_dmaDone, next_nxm, next_selfTest, next_linesOff;
	logic fifoInReady;

	assign busClear = pin.ctl.dcPowerLow || pin.ctl.init;
	assign grantIn = kindDma ? pin.ctl.npg : pin.ctl.bg5;

	// Next values of the whole sequencer.
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_kindDma = kindDma;
		next_ctlOut = ctlOut;
		next_addrOut = addrOut;
		next_addrOe = addrOe;
		next_dataOut = dataOut;
		next_dataOe = dataOe;
		next_slvReq = 1'b0;
		next_slvOffset = slvOffset;
		next_slvWrite = slvWrite;
		next_slvByte = slvByte;
		next_slvWdata = slvWdata;
		next_irqDone = 1'b0;
		next_dmaDone = 1'b0;
		next_nxm = 1'b0;
		push = 1'b0;
		pushWord = '0;
		next_selfTest = 1'b0;
		next_linesOff = paramsLoaded ? 1'b0 : linesDisabled;
		next_powerLowSeen = powerLowSeen || pin.ctl.dcPowerLow;
		// A test runs at the end of a clear only if power was low.
		if (ctrlClear && !busClear)
		begin
			next_selfTest = powerLowSeen;
			next_powerLowSeen = 1'b0;
		end
		case (state)
			S_IDLE, S_ARB:
			begin
				// Serving the host first avoids a stall while we wait for a grant.
				if (pin.ctl.msyn && hit && !ctlOut.bbsy)
				begin
					next_slvReq = 1'b1;
					next_slvOffset = offsetFull[7:0];
					next_slvWrite = pin.ctl.c1;
					next_slvByte = pin.ctl.c0;
					next_slvWdata = pin.data;
					next_state = S_SLV_WAIT;
				end
				else if (state == S_ARB)
				begin
					if (grantIn)
					begin
						next_ctlOut.nonprocessorRequest = 1'b0;
						next_ctlOut.requestLevelFive = 1'b0;
						next_ctlOut.sack = 1'b1;
						next_state = S_SACK;
					end
				end
				else if (irqReq)
				begin
					next_kindDma = 1'b0;
					next_ctlOut.requestLevelFive = 1'b1;
					next_state = S_ARB;
				end
				else if (dmaReq && fifoInReady)
				begin
					next_kindDma = 1'b1;
					next_ctlOut.nonprocessorRequest = 1'b1;
					next_state = S_ARB;
				end
			end
			S_SLV_WAIT:
			begin
				// The host may give up; then the access is abandoned.
				if (!pin.ctl.msyn)
				begin
					next_state = S_IDLE;
				end
				else if (slvAck)
				begin
					next_dataOut = slvRdata;
					next_dataOe = !slvWrite;
					next_ctlOut.ssyn = 1'b1;
					next_state = S_SLV_END;
				end
			end
			S_SLV_END:
			begin
				if (!pin.ctl.msyn)
				begin
					next_ctlOut.ssyn = 1'b0;
					next_dataOe = 1'b0;
					next_state = S_IDLE;
				end
			end
			S_SACK:
			begin
				// Take the bus once it is idle and the grant has gone.
				if (!pin.ctl.bbsy && !pin.ctl.ssyn && !grantIn)
				begin
					next_ctlOut.sack = 1'b0;
					next_ctlOut.bbsy = 1'b1;
					next_cnt = '0;
					if (kindDma)
					begin
						next_addrOut = dmaAddr;
						next_addrOe = 1'b1;
						next_ctlOut.c1 = hbus_pkg::C1_READ;
						next_ctlOut.c0 = hbus_pkg::C0_READ;
						next_state = S_DESKEW;
					end
					else
					begin
						next_dataOut = irqVector;
						next_dataOe = 1'b1;
						next_ctlOut.intr = 1'b1;
						next_state = S_INTR;
					end
				end
			end
			S_DESKEW:
			begin
				next_cnt = cnt + 1'b1;
				if (cnt == hbus_pkg::CNT_W'(hbus_pkg::DESKEW_CYC - 1))
				begin
					next_ctlOut.msyn = 1'b1;
					next_cnt = '0;
					next_state = S_DMA_WAIT;
				end
			end
			S_DMA_WAIT:
			begin
				next_cnt = cnt + 1'b1;
				if (pin.ctl.ssyn || cnt == hbus_pkg::CNT_W'(hbus_pkg::TIMEOUT_CYC - 1))
				begin
					push = 1'b1;
					pushWord.data = pin.data;
					pushWord.err = !pin.ctl.ssyn || pin.ctl.parityErr;
					next_nxm = pushWord.err;
					next_dmaDone = 1'b1;
					next_ctlOut.msyn = 1'b0;
					next_state = S_RELEASE;
				end
			end
			S_INTR:
			begin
				if (pin.ctl.ssyn)
				begin
					next_ctlOut.intr = 1'b0;
					next_dataOe = 1'b0;
					next_irqDone = 1'b1;
					next_state = S_RELEASE;
				end
			end
			S_RELEASE:
			begin
				if (!pin.ctl.ssyn)
				begin
					next_ctlOut.bbsy = 1'b0;
					next_addrOe = 1'b0;
					next_state = S_IDLE;
				end
			end
			default:
			begin
				next_state = S_IDLE;
			end
		endcase
		// A clear drops every bus line and parks the sequencer.
		if (busClear)
		begin
			next_state = S_IDLE;
			next_ctlOut = '0;
			next_addrOe = 1'b0;
			next_dataOe = 1'b0;
			next_linesOff = 1'b1;
			push = 1'b0;
		end
	end

	// Registers only.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= S_IDLE;
			cnt <= '0;
			kindDma <= 1'b0;
			ctlOut <= '0;
			ctlOe <= '0;
			addrOut <= '0;
			addrOe <= 1'b0;
			dataOut <= '0;
			dataOe <= 1'b0;
			slvReq <= 1'b0;
			slvOffset <= '0;
			slvWrite <= 1'b0;
			slvByte <= 1'b0;
			slvWdata <= '0;
			irqDone <= 1'b0;
			dmaDone <= 1'b0;
			nonexistentMemoryError <= 1'b0;
			powerLowSeen <= 1'b0;
			ctrlClear <= 1'b0;
			selfTestStart <= 1'b0;
			linesDisabled <= 1'b1;
			npgOut <= 1'b0;
			bg5Out <= 1'b0;
			faultLed <= '0;
			dsrRewired <= 1'b0;
			wrapMode <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			kindDma <= next_kindDma;
			ctlOut <= next_ctlOut;
			ctlOe <= next_ctlOut; // Enable high exactly while a line is pulled.
			addrOut <= next_addrOut;
			addrOe <= next_addrOe;
			dataOut <= next_dataOut;
			dataOe <= next_dataOe;
			slvReq <= next_slvReq;
			slvOffset <= next_slvOffset;
			slvWrite <= next_slvWrite;
			slvByte <= next_slvByte;
			slvWdata <= next_slvWdata;
			irqDone <= next_irqDone;
			dmaDone <= next_dmaDone;
			nonexistentMemoryError <= next_nxm;
			powerLowSeen <= next_powerLowSeen;
			ctrlClear <= busClear;
			selfTestStart <= next_selfTest;
			linesDisabled <= next_linesOff;
			// Grants we did not ask for travel on down the chain.
			npgOut <= pin.ctl.npg && !ctlOut.nonprocessorRequest && !ctlOut.sack;
			bg5Out <= pin.ctl.bg5 && !ctlOut.requestLevelFive && !ctlOut.sack;
			faultLed <= lineFault;
			dsrRewired <= pin.dsrSwitch;
			wrapMode <= pin.wrapSwitch;
		end
	end

	// Fetched words wait here; a full buffer holds off the next fetch.
	word_fifo #(
		.WIDTH($bits(hbus_pkg::dmaWord_t)),
		.DEPTH(hbus_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.flush(busClear),
		.inValid(push),
		.inReady(fifoInReady),
		.inData(pushWord),
		.outValid(wordValid),
		.outReady(wordReady),
		.outData(wordOut)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and covers.

	property p_decodeWindow;
		@(posedge mclk) disable iff (rst) slvReq |-> {10'h000, slvOffset} < WINDOW;
	endproperty
	a_decodeWindow: assert property (p_decodeWindow) else $error("offset outside window");

	property p_vector;
		@(posedge mclk) disable iff (rst) $rose(ctlOut.intr) |-> dataOe && dataOut == $past(irqVector);
	endproperty
	a_vector: assert property (p_vector) else $error("vector not driven");

	property p_levelFive;
		@(posedge mclk) disable iff (rst) $rose(ctlOut.intr) |-> $past(state) == S_SACK && !kindDma;
	endproperty
	a_levelFive: assert property (p_levelFive) else $error("interrupt without grant");

	property p_clear;
		@(posedge mclk) disable iff (rst) busClear |=> ctlOut == '0 && state == S_IDLE && ctrlClear;
	endproperty
	a_clear: assert property (p_clear) else $error("clear not applied");

	property p_selfTest;
		@(posedge mclk) disable iff (rst) selfTestStart |-> $past(powerLowSeen) && !ctrlClear;
	endproperty
	a_selfTest: assert property (p_selfTest) else $error("self-test without power low");

	property p_wordRead;
		@(posedge mclk) disable iff (rst) ctlOut.msyn |-> !ctlOut.c1 && !ctlOut.c0 && addrOe;
	endproperty
	a_wordRead: assert property (p_wordRead) else $error("fetch is not a word read");

	property p_parityNxm;
		@(posedge mclk) disable iff (rst)
			state == S_DMA_WAIT && pin.ctl.ssyn && pin.ctl.parityErr && !busClear
			|=> nonexistentMemoryError && dmaDone;
	endproperty
	a_parityNxm: assert property (p_parityNxm) else $error("parity error not reported");

	property p_linesOff;
		@(posedge mclk) disable iff (rst) ctrlClear |-> ##1 linesDisabled;
	endproperty
	a_linesOff: assert property (p_linesOff) else $error("lines not disabled");

	property p_grantFirst;
		@(posedge mclk) disable iff (rst) $rose(addrOe) |-> $past(state) == S_SACK && ctlOut.bbsy;
	endproperty
	a_grantFirst: assert property (p_grantFirst) else $error("address before grant");

	property p_msynDeskew;
		@(posedge mclk) disable iff (rst) $rose(addrOe) |-> !ctlOut.msyn [*8];
	endproperty
	a_msynDeskew: assert property (p_msynDeskew) else $error("deskew too short");

	c_fetch: cover property (@(posedge mclk) disable iff (rst) dmaDone && !nonexistentMemoryError);
	c_nxm: cover property (@(posedge mclk) disable iff (rst) nonexistentMemoryError);
	c_intr: cover property (@(posedge mclk) disable iff (rst) irqDone);
	c_slave: cover property (@(posedge mclk) disable iff (rst) slvReq ##[1:20] ctlOut.ssyn);
endmodule // host_bus_slave_dma

// >>> hdl/hbus_pkg.sv
// Shared constants and carrier types for the host bus front end.
package hbus_pkg;
	// Bus widths.
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	// Clock and bus timing.
	localparam int CLK_NS = 20;
	localparam int DESKEW_NS = 150;
	localparam int DESKEW_CYC = (DESKEW_NS + CLK_NS - 1) / CLK_NS;
	localparam int TIMEOUT_NS = 10000;
	localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 10;
	// Address decode memory layout: five variants of ten bases each.
	localparam logic [17:0] FIRST_BASE = 18'h3_E0E0;
	localparam logic [17:0] SLOT_STEP = 18'h0_0020;
	localparam int VARIANTS = 5;
	localparam int BASES_PER = 10;
	localparam int SLOTS = VARIANTS * BASES_PER;
	localparam int EMUL_BYTES = 32;
	localparam int MAX_GROUPS = 6;
	localparam int FIFO_DEPTH = 16;
	// Bus cycle function codes for a word read.
	localparam logic C1_READ = 1'h0;
	localparam logic C0_READ = 1'h0;

	// Control lines that the block may pull.
	typedef struct packed {
		logic msyn;
		logic ssyn;
		logic c1;
		logic c0;
		logic bbsy;
		logic sack;
		logic nonprocessorRequest;
		logic requestLevelFive;
		logic intr;
	} busCtl_t;

	// Control lines that the block observes.
	typedef struct packed {
		logic msyn;
		logic ssyn;
		logic c1;
		logic c0;
		logic bbsy;
		logic parityErr;
		logic npg;
		logic bg5;
		logic dcPowerLow;
		logic init;
	} busIn_t;

	// Every pin input, gathered for the synchroniser.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		busIn_t ctl;
		logic dsrSwitch;
		logic [3:0] baseAddressSwitch;
		logic [2*MAX_GROUPS-1:0] wrapSwitch;
	} pins_t;

	// One fetched word with its error mark.
	typedef struct packed {
		logic err;
		logic [DATA_W-1:0] data;
	} dmaWord_t;
endpackage

// >>> hdl/word_fifo.sv
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
)(
	// Clock, reset and flush.
	input wire logic mclk,
	input wire logic rst,
	input wire logic flush,
	// Filling side.
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side.
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PTR_W = $clog2(DEPTH);

	// Depth must be a power of two so the pointers wrap by themselves.
	if (DEPTH < 2 || (1 << PTR_W) != DEPTH)
	begin : g_bad_depth
		$error("word_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH]; // Storage array.
	logic [PTR_W-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic [PTR_W:0] count, next_count; // Words held.
	logic push, pop;

	assign inReady = count != (PTR_W + 1)'(DEPTH);
	assign outValid = count != '0;
	assign outData = mem[rdPtr];

	// Pointer and count arithmetic; a flush empties the buffer at once.
	always_comb
	begin
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wrPtr = wrPtr + PTR_W'(push);
		next_rdPtr = rdPtr + PTR_W'(pop);
		next_count = count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
		if (flush)
		begin
			next_wrPtr = '0;
			next_rdPtr = '0;
			next_count = '0;
		end
	end

	// Registers only.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
		if (push && !flush)
		begin
			mem[wrPtr] <= inData;
		end
	end
endmodule // word_fifo

// >>> verification/host_bus_model.sv
// Behavioural host bus partner: processor slave cycles, memory, grants and vector capture.
`timescale 1ns/1ps
module host_bus_model (
	// Clock.
	input wire logic mclk,
	// Lines that the block pulls.
	input wire logic [17:0] addrOut,
	input wire logic addrOe,
	input wire logic [15:0] dataOut,
	input wire logic dataOe,
	input wire hbus_pkg::busCtl_t ctlOut,
	input wire hbus_pkg::busCtl_t ctlOe,
	// Resolved lines that the block sees.
	output logic [17:0] addrIn,
	output logic [15:0] dataIn,
	output hbus_pkg::busIn_t ctlIn
);
	// Host drive; terminated lines read negated when nobody pulls them.
	logic [17:0] hAddr = '0;
	logic [15:0] hData = '0;
	logic [15:0] cpuData = '0;
	logic hMsyn = 0, hSsyn = 0, hC1 = 0, hPar = 0, npg = 0, bg5 = 0;
	logic dcPowerLow = 0, init = 0, mute = 0, parMode = 0, granted = 0, lvl5Seen = 0;
	logic [1:0] cSeen = 2'b11;
	logic [15:0] vecSeen = '0;
	int memWait = 2, dly = 0, early = 0;

	////////////////////////////////////////////////////////////////////////
	// Memory contents follow from the word address.
	function automatic logic [15:0] memWord(input logic [17:0] a);
		return a[16:1] ^ 16'hc3a5;
	endfunction

	// Wired lines: a line is asserted if any party pulls it.
	always_comb
	begin
		addrIn = hAddr | (addrOe ? addrOut : '0);
		dataIn = hData | cpuData | (dataOe ? dataOut : '0);
		ctlIn.msyn = hMsyn | (ctlOe.msyn & ctlOut.msyn);
		ctlIn.ssyn = hSsyn | (ctlOe.ssyn & ctlOut.ssyn);
		ctlIn.c1 = hC1 | (ctlOe.c1 & ctlOut.c1);
		ctlIn.c0 = ctlOe.c0 & ctlOut.c0;
		ctlIn.bbsy = ctlOe.bbsy & ctlOut.bbsy;
		ctlIn.parityErr = hPar;
		ctlIn.npg = npg;
		ctlIn.bg5 = bg5;
		ctlIn.dcPowerLow = dcPowerLow;
		ctlIn.init = init;
	end

	// Arbiter, memory slave and interrupt acceptor; all change just after the edge.
	always @(posedge mclk)
	begin
		if (ctlOut.sack)
		begin
			npg <= 0;
			bg5 <= 0;
		end
		else if (ctlOut.nonprocessorRequest && !ctlIn.bbsy && !bg5)
			npg <= 1;
		else if (ctlOut.requestLevelFive && !ctlIn.bbsy && !npg)
			bg5 <= 1;
		if (ctlOe.requestLevelFive && ctlOut.requestLevelFive)
			lvl5Seen <= 1;
		// Addressing without a grant in hand is counted as a fault.
		if (npg || bg5)
			granted <= 1;
		else if ($fell(ctlIn.bbsy))
			granted <= 0;
		if (addrOe && !granted)
			early <= early + 1;
		if (ctlIn.msyn && ctlOe.bbsy && !mute)
		begin
			dly <= dly + 1;
			if (dly == memWait)
			begin
				hSsyn <= 1;
				hData <= memWord(addrIn);
				hPar <= parMode;
				cSeen <= {ctlIn.c1, ctlIn.c0};
			end
		end
		else if (ctlOut.intr && ctlOe.intr && !hSsyn)
		begin
			hSsyn <= 1;
			vecSeen <= dataIn;
		end
		else if (!ctlOut.intr && !(ctlIn.msyn && ctlOe.bbsy))
		begin
			// Released lines go back to negated, never the last value.
			hSsyn <= 0;
			hData <= '0;
			hPar <= 0;
			dly <= 0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Processor slave cycle; ok stays low when nobody answers in 60 cycles.
	task automatic cpuCycle(input logic [17:0] a, input logic wr, input logic [15:0] wd,
		output logic ok, output logic [15:0] rd);
		int n;
		ok = 0;
		rd = '0;
		@(negedge mclk);
		hAddr = a;
		hC1 = wr;
		cpuData = wr ? wd : '0;
		@(negedge mclk);
		hMsyn = 1;
		for (n = 0; n < 60 && !ok; n++)
		begin
			@(posedge mclk);
			ok = ctlIn.ssyn;
			rd = dataIn;
		end
		@(negedge mclk);
		hMsyn = 0;
		for (n = 0; n < 60 && ctlIn.ssyn; n++)
			@(posedge mclk);
		@(negedge mclk);
		hAddr = '0;
		hC1 = 0;
		cpuData = '0;
	endtask
endmodule // host_bus_model

// >>> verification/host_bus_slave_dma_tb.sv
// Self-checking bench for the host bus slave, interrupt poster and word fetch block.
`timescale 1ns/1ps
module host_bus_slave_dma_tb;
	// Clock, reset, counters and the random source.
	logic mclk = 0;
	logic rst = 1;
	int nFail = 0, totalChecks = 0, nReq = 0, nDone = 0, nIrq = 0, nSt = 0, ackWait = 0;
	logic [31:0] seed = 32'h166e_53a5;
	// Inputs that the bench drives.
	logic [3:0] baseAddressSwitch = '0;
	logic dsrSwitch = 0, paramsLoaded = 0, slvAck = 0, irqReq = 0, dmaReq = 0, wordReady = 0;
	logic [11:0] wrapSwitch = '0;
	logic [15:0] slvRdata = '0, irqVector = '0, seenWd = '0;
	logic [17:0] dmaAddr = '0;
	logic [7:0] lineFault = '0, seenOff = '0;
	logic lastNxm = 0, seenWr = 0;
	// Outputs of the block and resolved bus lines.
	logic [17:0] addrIn, addrOut;
	logic [15:0] dataIn, dataOut, slvWdata;
	hbus_pkg::busIn_t ctlIn;
	hbus_pkg::busCtl_t ctlOut, ctlOe;
	hbus_pkg::dmaWord_t wordOut;
	logic addrOe, dataOe, npgOut, bg5Out, ctrlClear, selfTestStart, linesDisabled, slvReq;
	logic slvWrite, slvByte, irqDone, dmaDone, nonexistentMemoryError, wordValid, dsrRewired;
	logic [7:0] slvOffset, faultLed;
	logic [11:0] wrapMode;

	host_bus_slave_dma #(.NUM_EMUL(2), .DECODE_VARIANT(0)) u_dut (.*);
	host_bus_model u_host (.*);

	always #10 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	// Firmware stand-in: acknowledges hand-offs late and drops finished requests.
	always @(negedge mclk)
	begin
		if (ackWait != 0)
			ackWait <= ackWait - 1;
		slvAck <= (ackWait == 1);
		if (slvReq)
		begin
			nReq <= nReq + 1;
			seenOff <= slvOffset;
			seenWr <= slvWrite;
			seenWd <= slvWdata;
			ackWait <= 3;
		end
		if (dmaDone)
		begin
			nDone <= nDone + 1;
			lastNxm <= nonexistentMemoryError;
			dmaReq <= 0;
		end
		if (irqDone)
		begin
			nIrq <= nIrq + 1;
			irqReq <= 0;
		end
		if (selfTestStart)
			nSt <= nSt + 1;
	end

	// Galois shift register; the sequence repeats from run to run.
	function automatic logic [31:0] nextRand();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0000_0000);
		return seed;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			nFail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic finalReport();
		$display("Checks %0d, mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// One processor access, with the expected hand-off to the firmware.
	task automatic hostAccess(input logic [17:0] a, input logic wr, input logic [15:0] wd,
		input logic hit, input logic [7:0] off);
		logic ok;
		logic [15:0] rd;
		int n0;
		n0 = nReq;
		slvRdata = nextRand();
		u_host.cpuCycle(a, wr, wd, ok, rd);
		check("slave answer", ok, hit);
		check("slave hand-off", nReq - n0, hit);
		if (hit)
		begin
			check("slave offset", seenOff, off);
			check("slave direction", seenWr, wr);
			check("slave byte", slvByte, 0);
			if (wr)
				check("slave write data", seenWd, wd);
			else
				check("slave read data", rd, slvRdata);
		end
	endtask

	// One fetch; a parity error or a silent memory must come back as an error.
	task automatic fetch(input logic [17:0] a, input logic par);
		int n0, k;
		n0 = nDone;
		u_host.parMode = par;
		u_host.memWait = nextRand() & 7;
		dmaAddr = a;
		dmaReq = 1;
		for (k = 0; k < 2000 && nDone == n0; k++)
			@(negedge mclk);
		check("fetch done", k < 2000, 1);
		check("fetch error", lastNxm, par | u_host.mute);
		if (!u_host.mute)
			check("word read code", u_host.cSeen, 2'b00);
	endtask

	task automatic pop(output logic [16:0] w);
		for (int k = 0; k < 100 && wordValid !== 1'b1; k++)
			@(negedge mclk);
		w = wordOut;
		wordReady = 1;
		@(negedge mclk);
		wordReady = 0;
	endtask

	// The whole run needs well under 30000 cycles; twice that means a hang.
	initial
	begin
		#(20 * 60000);
		nFail++;
		finalReport();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] r;
		logic [17:0] a;
		logic [16:0] w;
		logic [16:0] q[$];
		int n0;
		int swList[4] = '{0, 3, 9, 10};
		cyc(12);
		rst = 0;
		cyc(6);
		check("lines disabled", linesDisabled, 1);
		check("fifo empty", wordValid, 0);
		// Option switches and fault indicators follow their pins.
		for (int i = 0; i < 4; i++)
		begin
			r = nextRand();
			dsrSwitch = r[0];
			wrapSwitch = r[12:1];
			lineFault = r[20:13];
			cyc(8);
			check("dsr rewired", dsrRewired, r[0]);
			check("wrap mode", wrapMode, r[12:1]);
			check("fault led", faultLed, r[20:13]);
		end
		$display("Test options done");
		// Base address per switch, window edges and a disabled decode.
		foreach (swList[i])
		begin
			baseAddressSwitch = swList[i];
			cyc(6);
			r = nextRand();
			a = hbus_pkg::FIRST_BASE + 18'(swList[i]) * hbus_pkg::SLOT_STEP;
			hostAccess(a + 18'({r[5:1], 1'b0}), 0, '0, swList[i] < 10, {r[5:1], 1'b0});
			hostAccess(a + 18'd64, 0, '0, 0, 8'h00);
			hostAccess(a - 18'd2, 1, r[31:16], 0, 8'h00);
		end
		baseAddressSwitch = 0;
		cyc(6);
		hostAccess(hbus_pkg::FIRST_BASE + 18'd62, 1, 16'h5a3c, 1, 8'h3e);
		$display("Test slave done");
		// Interrupts carry the programmed vector at level five.
		for (int i = 0; i < 3; i++)
		begin
			n0 = nIrq;
			u_host.lvl5Seen = 0;
			irqVector = nextRand();
			irqReq = 1;
			for (int k = 0; k < 500 && nIrq == n0; k++)
				@(negedge mclk);
			check("vector", u_host.vecSeen, irqVector);
			check("level five", u_host.lvl5Seen, 1);
		end
		$display("Test interrupt done");
		// Fetches with and without parity errors, then a silent memory.
		for (int i = 0; i < 6; i++)
		begin
			r = nextRand();
			a = {r[17:1], 1'b0};
			fetch(a, r[20]);
			pop(w);
			check("fifo word", w, {r[20], u_host.memWord(a)});
		end
		u_host.mute = 1;
		fetch(18'h0_0100, 0);
		pop(w);
		check("timeout mark", w[16], 1);
		u_host.mute = 0;
		check("grant before address", u_host.early, 0);
		$display("Test fetch done");
		// Fill until refused, then drain with the last fetch pending.
		for (int i = 0; i < 16; i++)
		begin
			a = {nextRand() & 18'h1_fffe};
			fetch(a, 0);
			q.push_back({1'b0, u_host.memWord(a)});
		end
		n0 = nDone;
		dmaAddr = 18'h2_0aa2;
		q.push_back({1'b0, u_host.memWord(18'h2_0aa2)});
		dmaReq = 1;
		cyc(40);
		check("full refused", nDone - n0, 0);
		check("no request when full", ctlOut.nonprocessorRequest, 0);
		// Grants that the block did not ask for must travel on down the chain.
		u_host.npg = 1;
		u_host.bg5 = 1;
		cyc(6);
		check("npg passed on", npgOut, 1);
		check("bg5 passed on", bg5Out, 1);
		u_host.npg = 0;
		u_host.bg5 = 0;
		cyc(6);
		while (q.size() > 0)
		begin
			cyc((nextRand() & 3) + 1);
			pop(w);
			check("drained word", w, q.pop_front());
		end
		check("fifo empty", wordValid, 0);
		$display("Test fifo done");
		// Clears: initialize alone skips the self-test, power low runs it.
		fetch(18'h0_0040, 0);
		paramsLoaded = 1;
		cyc(1);
		paramsLoaded = 0;
		cyc(2);
		check("lines enabled", linesDisabled, 0);
		n0 = nSt;
		u_host.init = 1;
		cyc(8);
		check("clear on init", ctrlClear, 1);
		check("flushed", wordValid, 0);
		u_host.init = 0;
		cyc(30);
		check("no self-test", nSt - n0, 0);
		check("lines disabled", linesDisabled, 1);
		check("clear ends", ctrlClear, 0);
		u_host.dcPowerLow = 1;
		cyc(8);
		check("clear on power low", ctrlClear, 1);
		u_host.dcPowerLow = 0;
		cyc(30);
		check("self-test once", nSt - n0, 1);
		$display("Test clear done");
		finalReport();
	end
endmodule // host_bus_slave_dma_tb
